// ==== logic/pmce_regs.svh ====
// Register offsets, field positions and reset values of the monitor control
`ifndef PMCE_REGS_SVH
`define PMCE_REGS_SVH

`define PMCE_OFF_MAIN_CTRL 12'h180
`define PMCE_OFF_EN_SET 12'h184
`define PMCE_OFF_EN_CLR 12'h188

`define PMCE_CTRL_MASK_EN_BIT 3
`define PMCE_CTRL_CYC_RST_BIT 2
`define PMCE_CTRL_EVT_RST_BIT 1
`define PMCE_CTRL_CNT_EN_BIT 0
`define PMCE_CTRL_NUM_LSB 11
`define PMCE_CTRL_NUM_MSB 15
`define PMCE_NUM_EVENT_CNT 5'h04

`define PMCE_EN_CYCLE_BIT 31
`define PMCE_EN_EVT_MSB 3

`define PMCE_CTRL_RESET 32'h0000_2000
`define PMCE_EN_RESET 32'h0000_0000

`endif

// ==== logic/pmce_pkg.sv ====
// Types shared by the monitor control design
package pmce_pkg;
    typedef logic [11:0] pmce_addr_t;
    typedef logic [31:0] pmce_word_t;
    typedef logic [3:0] pmce_evt_en_t;
    typedef enum logic [1:0] {
        PMCE_SEL_NONE = 2'b00,
        PMCE_SEL_CTRL = 2'b01,
        PMCE_SEL_SET = 2'b10,
        PMCE_SEL_CLR = 2'b11
    } pmce_sel_t;
endpackage

// ==== logic/pmce_enable_bit.sv ====
// One counter enable flip-flop with set and clear strobes
`timescale 1ns/1ps
module pmce_enable_bit (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Strobes
    input wire logic set_i,
    input wire logic clr_i,
    // State
    output logic en_o
);
    logic en_q;
    logic en_d;

    // Set wins over clear when both land in one write cycle
    always_comb begin
        en_d = en_q;
        if (clr_i) begin
            en_d = 1'b0;
        end
        if (set_i) begin
            en_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_q <= 1'b0;
        end else begin
            en_q <= en_d;
        end
    end

    assign en_o = en_q;
endmodule

// ==== logic/pmce_ctrl.sv ====
// Monitor main control and count-enable register bank
`timescale 1ns/1ps
`include "pmce_regs.svh"

// How it works
// - Event-counter quantity field reads constant four; writes ignored.
// - With gating permission set, stream gate operation switches monitoring.
// - Master enable clear keeps the unit inactive despite gating permission.
// - Writing one to cycle reset clears cycle tally; bit reads zero.
// - Writing one to event reset clears all event tallies; reads zero.
// - Master enable is a global switch over every individual enable.
// - Set register top bit enables cycle tally, low bits event tallies.
// - Set and clear registers share one enable state, read identically.
// - Writing zero to a set bit changes nothing; zero means disabled.
// - Cycle enable bit reads one while the cycle tally is enabled.
// - Event enable bit reads one while that event tally is enabled.
// - Clear register top bit disables cycle tally, low bits event tallies.
module pmce_ctrl
    import pmce_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic reg_sel_i,
    input wire logic reg_wr_i,
    input wire pmce_addr_t reg_addr_i,
    input wire pmce_word_t reg_wdata_i,
    output pmce_word_t reg_rdata_o,
    // Command-stream gate operation
    input wire logic stream_gate_valid_i,
    input wire logic stream_gate_on_i,
    // Counter controls
    output logic cycle_tally_run_o,
    output pmce_evt_en_t event_tally_run_o,
    output logic cycle_tally_clear_o,
    output logic event_tally_clear_o,
    output logic monitor_active_o
);

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic pmce_sel_t decode(input pmce_addr_t a);
        unique case (a)
            `PMCE_OFF_MAIN_CTRL: decode = PMCE_SEL_CTRL;
            `PMCE_OFF_EN_SET: decode = PMCE_SEL_SET;
            `PMCE_OFF_EN_CLR: decode = PMCE_SEL_CLR;
            default: decode = PMCE_SEL_NONE;
        endcase
    endfunction

    pmce_sel_t sel;
    logic wr_ctrl;
    logic wr_set;
    logic wr_clr;

    always_comb begin
        sel = reg_sel_i ? decode(reg_addr_i) : PMCE_SEL_NONE;
        wr_ctrl = reg_wr_i && (sel == PMCE_SEL_CTRL);
        wr_set = reg_wr_i && (sel == PMCE_SEL_SET);
        wr_clr = reg_wr_i && (sel == PMCE_SEL_CLR);
    end

    // ************************************************************
    // Main control
    // ************************************************************
    logic cnt_en_q;
    logic cnt_en_d;
    logic mask_en_q;
    logic mask_en_d;
    logic gate_on_q;
    logic gate_on_d;
    logic cyc_clr_q;
    logic cyc_clr_d;
    logic evt_clr_q;
    logic evt_clr_d;

    always_comb begin
        cnt_en_d = cnt_en_q;
        mask_en_d = mask_en_q;
        gate_on_d = gate_on_q;
        // Reset strobes last one cycle, never stored as readable state
        cyc_clr_d = wr_ctrl && reg_wdata_i[`PMCE_CTRL_CYC_RST_BIT];
        evt_clr_d = wr_ctrl && reg_wdata_i[`PMCE_CTRL_EVT_RST_BIT];
        if (wr_ctrl) begin
            cnt_en_d = reg_wdata_i[`PMCE_CTRL_CNT_EN_BIT];
            mask_en_d = reg_wdata_i[`PMCE_CTRL_MASK_EN_BIT];
        end
        // Operation ignored unless software granted permission
        if (stream_gate_valid_i && mask_en_q) begin
            gate_on_d = stream_gate_on_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_en_q <= 1'b0;
            mask_en_q <= 1'b0;
            gate_on_q <= 1'b1;
            cyc_clr_q <= 1'b0;
            evt_clr_q <= 1'b0;
        end else begin
            cnt_en_q <= cnt_en_d;
            mask_en_q <= mask_en_d;
            gate_on_q <= gate_on_d;
            cyc_clr_q <= cyc_clr_d;
            evt_clr_q <= evt_clr_d;
        end
    end

    // ************************************************************
    // Shared enable state
    // ************************************************************
    logic [4:0] en_set;
    logic [4:0] en_clr;
    logic [4:0] en_state;

    always_comb begin
        // Zero bits in either write leave state untouched
        en_set = {reg_wdata_i[`PMCE_EN_CYCLE_BIT],
                  reg_wdata_i[`PMCE_EN_EVT_MSB:0]} & {5{wr_set}};
        en_clr = {reg_wdata_i[`PMCE_EN_CYCLE_BIT],
                  reg_wdata_i[`PMCE_EN_EVT_MSB:0]} & {5{wr_clr}};
    end

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_en
            pmce_enable_bit u_bit (
                .core_clk_i(core_clk_i),
                .rst_n_i(rst_n_i),
                .set_i(en_set[g]),
                .clr_i(en_clr[g]),
                .en_o(en_state[g])
            );
        end
    endgenerate

    // ************************************************************
    // Outputs and readback
    // ************************************************************
    logic active;
    pmce_word_t rdata_d;
    pmce_word_t rdata_q;
    logic cyc_run_q;
    logic cyc_run_d;
    pmce_evt_en_t evt_run_q;
    pmce_evt_en_t evt_run_d;
    logic active_q;

    always_comb begin
        // Gating only matters while permission is granted
        active = cnt_en_q && (!mask_en_q || gate_on_q);
        cyc_run_d = active && en_state[4];
        evt_run_d = {4{active}} & en_state[3:0];
        rdata_d = 32'h0000_0000;
        unique case (sel)
            PMCE_SEL_CTRL: begin
                rdata_d[`PMCE_CTRL_NUM_MSB:`PMCE_CTRL_NUM_LSB] =
                    `PMCE_NUM_EVENT_CNT;
                rdata_d[`PMCE_CTRL_MASK_EN_BIT] = mask_en_q;
                rdata_d[`PMCE_CTRL_CNT_EN_BIT] = cnt_en_q;
            end
            PMCE_SEL_SET, PMCE_SEL_CLR: begin
                rdata_d[`PMCE_EN_CYCLE_BIT] = en_state[4];
                rdata_d[`PMCE_EN_EVT_MSB:0] = en_state[3:0];
            end
            PMCE_SEL_NONE: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0000_0000;
            cyc_run_q <= 1'b0;
            evt_run_q <= 4'h0;
            active_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            cyc_run_q <= cyc_run_d;
            evt_run_q <= evt_run_d;
            active_q <= active;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign cycle_tally_run_o = cyc_run_q;
    assign event_tally_run_o = evt_run_q;
    assign cycle_tally_clear_o = cyc_clr_q;
    assign event_tally_clear_o = evt_clr_q;
    assign monitor_active_o = active_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence ctrl_rd_s;
        reg_sel_i && !reg_wr_i && reg_addr_i == `PMCE_OFF_MAIN_CTRL;
    endsequence

    sequence set_rd_s;
        reg_sel_i && !reg_wr_i && reg_addr_i == `PMCE_OFF_EN_SET;
    endsequence

    sequence clr_rd_s;
        reg_sel_i && !reg_wr_i && reg_addr_i == `PMCE_OFF_EN_CLR;
    endsequence

    num_field_const_a: assert property (
        ctrl_rd_s |=> reg_rdata_o[15:11] == `PMCE_NUM_EVENT_CNT &&
            reg_rdata_o[2:1] == 2'b00)
        else $error("control readback wrong");
    // Operation value taken two edges back, the pin may move since
    gate_permit_a: assert property (
        stream_gate_valid_i && mask_en_q && cnt_en_q && !wr_ctrl
        |=> ##1 monitor_active_o == $past(stream_gate_on_i, 2))
        else $error("gate operation not applied");
    gate_denied_a: assert property (
        stream_gate_valid_i && !mask_en_q |=> gate_on_q == $past(gate_on_q))
        else $error("gate operation taken without permission");
    master_off_a: assert property (
        !cnt_en_q |=> !monitor_active_o)
        else $error("active without master enable");
    cyc_clear_a: assert property (
        wr_ctrl && reg_wdata_i[`PMCE_CTRL_CYC_RST_BIT]
        |=> cycle_tally_clear_o ##1 (!cycle_tally_clear_o ||
            $past(wr_ctrl && reg_wdata_i[`PMCE_CTRL_CYC_RST_BIT])))
        else $error("cycle clear strobe wrong");
    cyc_clear_src_a: assert property (
        cycle_tally_clear_o |->
            $past(wr_ctrl && reg_wdata_i[`PMCE_CTRL_CYC_RST_BIT]))
        else $error("cycle clear strobe without write");
    evt_clear_a: assert property (
        wr_ctrl && reg_wdata_i[1] |=> event_tally_clear_o)
        else $error("event clear strobe missing");
    evt_clear_src_a: assert property (
        event_tally_clear_o |->
            $past(wr_ctrl && reg_wdata_i[`PMCE_CTRL_EVT_RST_BIT]))
        else $error("event clear strobe without write");
    global_off_a: assert property (
        !cnt_en_q |=> !cycle_tally_run_o && event_tally_run_o == 4'h0)
        else $error("counter runs while unit off");
    ctrl_bits_read_a: assert property (
        ctrl_rd_s |=>
            reg_rdata_o[`PMCE_CTRL_CNT_EN_BIT] == $past(cnt_en_q) &&
            reg_rdata_o[`PMCE_CTRL_MASK_EN_BIT] == $past(mask_en_q))
        else $error("control bits readback wrong");
    set_enable_a: assert property (
        wr_set && reg_wdata_i[`PMCE_EN_CYCLE_BIT]
        |=> en_state[4] ##1 cycle_tally_run_o == active_q)
        else $error("cycle enable not set");
    shared_read_a: assert property (
        clr_rd_s |=> reg_rdata_o[3:0] == $past(en_state[3:0]) &&
            reg_rdata_o[31] == $past(en_state[4]))
        else $error("clear register readback wrong");
    zero_write_a: assert property (
        wr_set && !reg_wdata_i[0] |=> en_state[0] == $past(en_state[0]))
        else $error("zero write changed enable");

    // ************************************************************
    // Readback and run checks
    // ************************************************************
    cyc_readback_a: assert property (
        set_rd_s |=>
            reg_rdata_o[`PMCE_EN_CYCLE_BIT] == $past(en_state[4]))
        else $error("cycle enable readback wrong");
    evt_readback_a: assert property (
        set_rd_s |=>
            reg_rdata_o[`PMCE_EN_EVT_MSB:0] == $past(en_state[3:0]))
        else $error("event enable readback wrong");
    clr_disable_a: assert property (
        wr_clr && reg_wdata_i[0] |=> !en_state[0] ##1 !event_tally_run_o[0])
        else $error("event enable not cleared");
    clr_zero_a: assert property (
        wr_clr && !reg_wdata_i[1]
        |=> en_state[1] == $past(en_state[1]))
        else $error("zero clear bit changed enable");
    // Run outputs trail the enable state by one register stage
    cyc_run_gate_a: assert property (
        cycle_tally_run_o |-> $past(cnt_en_q) && $past(en_state[4]))
        else $error("cycle tally runs without enables");
    evt_run_gate_a: assert property (
        event_tally_run_o != 4'h0 |-> $past(cnt_en_q) &&
            (event_tally_run_o & ~$past(en_state[3:0])) == 4'h0)
        else $error("event tally runs without enables");
    set_reserved_a: assert property (
        set_rd_s |=> reg_rdata_o[30:4] == 27'h0)
        else $error("set register reserved bits not zero");
    clr_reserved_a: assert property (
        clr_rd_s |=> reg_rdata_o[30:4] == 27'h0)
        else $error("clear register reserved bits not zero");
    ctrl_reserved_a: assert property (
        ctrl_rd_s |=> reg_rdata_o[31:16] == 16'h0 &&
            reg_rdata_o[10:4] == 7'h0)
        else $error("control reserved bits not zero");
    idle_read_a: assert property (
        sel == PMCE_SEL_NONE |=> reg_rdata_o == 32'h0000_0000)
        else $error("read data not zero without a mapped access");
endmodule

// ==== verification/pmce_ctrl_test.sv ====
// Self-checking bench for the monitor control register bank
`timescale 1ns/1ps
`include "pmce_regs.svh"

module pmce_ctrl_test
    import pmce_pkg::*;
();

    // ********************
    // Signals and instance
    // ********************
    logic core_clk_i;
    logic rst_n_i;
    logic reg_sel_i;
    logic reg_wr_i;
    pmce_addr_t reg_addr_i;
    pmce_word_t reg_wdata_i;
    pmce_word_t reg_rdata_o;
    logic stream_gate_valid_i;
    logic stream_gate_on_i;
    logic cycle_tally_run_o;
    pmce_evt_en_t event_tally_run_o;
    logic cycle_tally_clear_o;
    logic event_tally_clear_o;
    logic monitor_active_o;
    int n_mismatch;
    int total_checks;
    int n_cycles;

    pmce_ctrl dut (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .reg_sel_i(reg_sel_i),
        .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .stream_gate_valid_i(stream_gate_valid_i),
        .stream_gate_on_i(stream_gate_on_i),
        .cycle_tally_run_o(cycle_tally_run_o),
        .event_tally_run_o(event_tally_run_o),
        .cycle_tally_clear_o(cycle_tally_clear_o),
        .event_tally_clear_o(event_tally_clear_o),
        .monitor_active_o(monitor_active_o)
    );

    // ********************
    // Access tasks
    // ********************
    task chk(input pmce_word_t seen, input pmce_word_t exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Inputs move only by NBA at the edge, so no sampling race
    task wr(input pmce_addr_t a, input pmce_word_t d);
        @(posedge core_clk_i);
        reg_sel_i <= 1'b1;
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_sel_i <= 1'b0;
        reg_wr_i <= 1'b0;
        #1;
    endtask

    task rd(input pmce_addr_t a, input pmce_word_t exp);
        @(posedge core_clk_i);
        reg_sel_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_sel_i <= 1'b0;
        #1;
        chk(reg_rdata_o, exp);
    endtask

    task gate(input logic on);
        @(posedge core_clk_i);
        stream_gate_valid_i <= 1'b1;
        stream_gate_on_i <= on;
        @(posedge core_clk_i);
        stream_gate_valid_i <= 1'b0;
        #1;
    endtask

    task settle;
        @(posedge core_clk_i);
        #1;
    endtask

    // Order: cycle clear, event clear, cycle run, event runs, active
    task outs(input logic [7:0] exp);
        chk({24'h0, cycle_tally_clear_o, event_tally_clear_o,
            cycle_tally_run_o, event_tally_run_o, monitor_active_o},
            {24'h0, exp});
    endtask

    task finish_test;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ********************
    // Clock, reset, timeout
    // ********************
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    // Sequence needs a few hundred cycles at most
    always @(posedge core_clk_i) begin
        n_cycles <= n_cycles + 1;
        if (n_cycles == 2000) begin
            n_mismatch++;
            finish_test;
        end
    end

    // ********************
    // Main sequence
    // ********************
    initial begin
        n_mismatch = 0;
        total_checks = 0;
        n_cycles = 0;
        rst_n_i = 1'b0;
        reg_sel_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_addr_i = 12'h000;
        reg_wdata_i = 32'h0;
        stream_gate_valid_i = 1'b0;
        stream_gate_on_i = 1'b0;
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        settle;
        outs(8'h00);
        rd(`PMCE_OFF_MAIN_CTRL, `PMCE_CTRL_RESET);
        rd(`PMCE_OFF_EN_SET, `PMCE_EN_RESET);
        rd(`PMCE_OFF_EN_CLR, `PMCE_EN_RESET);
        wr(`PMCE_OFF_MAIN_CTRL, 32'hffff_fff6);
        outs(8'hc0);
        settle;
        outs(8'h00);
        rd(`PMCE_OFF_MAIN_CTRL, 32'h0000_2000);
        wr(`PMCE_OFF_EN_SET, 32'h8000_000f);
        settle;
        outs(8'h00);
        rd(`PMCE_OFF_EN_SET, 32'h8000_000f);
        rd(`PMCE_OFF_EN_CLR, 32'h8000_000f);
        wr(`PMCE_OFF_EN_SET, 32'h7fff_fff0);
        rd(`PMCE_OFF_EN_SET, 32'h8000_000f);
        wr(`PMCE_OFF_MAIN_CTRL, 32'h0000_0001);
        settle;
        outs(8'h3f);
        wr(`PMCE_OFF_MAIN_CTRL, 32'h0000_0005);
        outs(8'hbf);
        settle;
        outs(8'h3f);
        wr(`PMCE_OFF_EN_SET, 32'h0000_0000);
        rd(`PMCE_OFF_EN_SET, 32'h8000_000f);
        wr(`PMCE_OFF_EN_CLR, 32'h8000_0005);
        settle;
        outs(8'h15);
        rd(`PMCE_OFF_EN_CLR, 32'h0000_000a);
        rd(`PMCE_OFF_EN_SET, 32'h0000_000a);
        // Unmapped place must neither answer nor disturb state
        wr(12'h18c, 32'hffff_ffff);
        rd(12'h18c, 32'h0000_0000);
        rd(`PMCE_OFF_EN_SET, 32'h0000_000a);
        gate(1'b0);
        settle;
        outs(8'h15);
        wr(`PMCE_OFF_MAIN_CTRL, 32'h0000_0009);
        rd(`PMCE_OFF_MAIN_CTRL, 32'h0000_2009);
        gate(1'b0);
        settle;
        outs(8'h00);
        gate(1'b1);
        settle;
        outs(8'h15);
        wr(`PMCE_OFF_MAIN_CTRL, 32'h0000_0008);
        settle;
        outs(8'h00);
        gate(1'b1);
        settle;
        outs(8'h00);
        // Reset mid-run must bring the gate state back to on
        gate(1'b0);
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        settle;
        outs(8'h00);
        rd(`PMCE_OFF_EN_CLR, `PMCE_EN_RESET);
        rd(`PMCE_OFF_MAIN_CTRL, `PMCE_CTRL_RESET);
        wr(`PMCE_OFF_MAIN_CTRL, 32'h0000_0009);
        wr(`PMCE_OFF_EN_SET, 32'h8000_0000);
        settle;
        outs(8'h21);
        finish_test;
    end

endmodule
